// file: core/wm_state_pkg.sv
package wm_state_pkg;

    // ****************************************
    // packet header layout
    // ****************************************
    localparam int CMD_TYPE_HI = 31;
    localparam int CMD_TYPE_LO = 29;
    localparam int CMD_SUB_HI = 28;
    localparam int CMD_SUB_LO = 27;
    localparam int OPC_HI = 26;
    localparam int OPC_LO = 24;
    localparam int SUBOPC_HI = 23;
    localparam int SUBOPC_LO = 16;
    localparam int LEN_HI = 7;
    localparam int LEN_LO = 0;
    localparam logic [2:0] GRAPHICS_COMMAND_TYPE = 3'h3;
    localparam logic [1:0] THREE_D_COMMAND_SUBTYPE = 2'h3;
    localparam logic [2:0] PIPELINED_STATE_OPCODE = 3'h0;
    localparam logic [7:0] RASTERIZER_STATE_SUBOPC = 8'h14;
    localparam logic [7:0] LEN_DEFAULT = 8'h07;

    // ****************************************
    // payload field positions (word index, bits)
    // ****************************************
    localparam logic [7:0] WORD_KERNEL = 8'h01;
    localparam logic [7:0] WORD_THREAD = 8'h02;
    localparam logic [7:0] WORD_SCRATCH = 8'h03;
    localparam logic [7:0] WORD_DEPTH = 8'h04;
    localparam int KPTR_LO = 6;
    localparam int BTCNT_HI = 25;
    localparam int BTCNT_LO = 18;
    localparam int PRIO_BIT = 17;
    localparam int FPMODE_BIT = 16;
    localparam int ILLOP_EXC_BIT = 13;
    localparam int MASKSTK_EXC_BIT = 11;
    localparam int SW_EXC_BIT = 7;
    localparam int SCR_BASE_LO = 10;
    localparam int SCR_SIZE_HI = 3;
    localparam int SCR_SIZE_LO = 0;
    localparam logic [3:0] SCR_SIZE_MAX = 4'hb;
    localparam logic [21:0] SCR_ONE_KB = 22'h000400;
    localparam int STATS_EN_BIT = 31;
    localparam int DEPTH_CLEAR_BIT = 30;

    // ****************************************
    // thread control word bit positions
    // ****************************************
    localparam int TCW_ILLOP_MASK_BIT = 12;
    localparam int TCW_SW_EXC_BIT = 13;

    // ****************************************
    // scoreboard
    // ****************************************
    localparam int SB_DEPTH = 8;
    localparam int SB_IDX_W = 3;
    localparam int PIX_W = 16;
    localparam logic [3:0] SB_FULL = 4'h8;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_STATS = 4'h4;
    localparam logic [3:0] REG_CONTROL = 4'h8;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_HDR_ERR_BIT = 1;
    localparam int ST_LOADED_BIT = 2;
    localparam int CTL_DISP_EN_BIT = 0;
    localparam logic CTL_DISP_EN_RESET = 1'b1;

    typedef enum logic {ST_HEADER, ST_PAYLOAD} decode_state_type;

endpackage : wm_state_pkg

// file: core/windower_state_packet_decode.sv
// Summary of operation
// - header needs command type 3h, subtype 3h
// - opcode 0h and sub-opcode 14h select packet
// - length field counts payload, total minus two
// - kernel pointer from word 1, 64-byte aligned
// - binding-table count, prefetch hint only
// - bit 17 picks normal or high priority
// - illegal-opcode or mask-stack enable to bit 12
// - software exception enable to bit 13
// - scratch base from word 3, 1 KB aligned
// - scratch size n means 1 KB shifted n, n capped at 11
// - statistics count only while enabled
// - depth clear initialises instead of testing
// - scoreboard keeps pixel results retiring in order
`timescale 1ns/1ps
`default_nettype none

module windower_state_packet_decode (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_N,
    // packet word stream
    input wire logic i_PKT_VALID,
    input wire logic [31:0] i_PKT_DATA,
    output logic o_PKT_READY,
    // register port
    input wire logic [3:0] i_REG_ADDR,
    input wire logic [31:0] i_REG_WDATA,
    input wire logic i_REG_WR,
    input wire logic i_REG_RD,
    output logic [31:0] o_REG_RDATA,
    // active dispatch state
    output logic [25:0] o_KERNEL_PTR,
    output logic [7:0] o_BT_COUNT,
    output logic o_HIGH_PRIO,
    output logic o_ALT_FP_MODE,
    output logic [31:0] o_THREAD_CTL_WORD,
    output logic [21:0] o_SCRATCH_BASE,
    output logic [21:0] o_SCRATCH_BYTES,
    output logic o_STATS_EN,
    output logic o_DEPTH_INIT,
    // thread dispatch and completion
    input wire logic i_DISP_REQ,
    input wire logic [15:0] i_DISP_PIXEL,
    output logic o_DISP_ACK,
    output logic [2:0] o_DISP_TID,
    input wire logic i_DONE_VALID,
    input wire logic [2:0] i_DONE_TID,
    output logic o_RETIRE,
    output logic [2:0] o_RETIRE_TID
);

    // ****************************************
    // packet decode
    // ****************************************
    wm_state_pkg::decode_state_type state_r, state_nxt;
    logic [7:0] left_r;
    logic [7:0] word_r;
    logic [25:0] kptr_s;
    logic [7:0] btcnt_s;
    logic prio_s;
    logic fpmode_s;
    logic exc_mask_s;
    logic exc_sw_s;
    logic [21:0] scr_base_s;
    logic [3:0] scr_size_s;
    logic stats_s;
    logic dclear_s;
    logic hdr_err_r;
    logic loaded_r;

    wire logic take_word = i_PKT_VALID & o_PKT_READY;
    wire logic hdr_type_ok = (i_PKT_DATA[wm_state_pkg::CMD_TYPE_HI:wm_state_pkg::CMD_TYPE_LO]
        == wm_state_pkg::GRAPHICS_COMMAND_TYPE)
        && (i_PKT_DATA[wm_state_pkg::CMD_SUB_HI:wm_state_pkg::CMD_SUB_LO]
        == wm_state_pkg::THREE_D_COMMAND_SUBTYPE);
    wire logic hdr_opc_ok = (i_PKT_DATA[wm_state_pkg::OPC_HI:wm_state_pkg::OPC_LO]
        == wm_state_pkg::PIPELINED_STATE_OPCODE)
        && (i_PKT_DATA[wm_state_pkg::SUBOPC_HI:wm_state_pkg::SUBOPC_LO]
        == wm_state_pkg::RASTERIZER_STATE_SUBOPC);
    // header bits 15:8 are not looked at; the test sender puts random values in them
    wire logic hdr_ok = hdr_type_ok & hdr_opc_ok;
    wire logic in_header = (state_r == wm_state_pkg::ST_HEADER);
    wire logic hdr_take = take_word & in_header;
    wire logic pay_take = take_word & ~in_header;
    wire logic last_word = pay_take & (left_r == 8'h00);
    wire logic [7:0] hdr_len = i_PKT_DATA[wm_state_pkg::LEN_HI:wm_state_pkg::LEN_LO];
    // next shadow values; the active copies load these so the final word counts
    // whichever field it carries, even in a short packet
    wire logic sel_kernel = (word_r == wm_state_pkg::WORD_KERNEL);
    wire logic sel_thread = (word_r == wm_state_pkg::WORD_THREAD);
    wire logic sel_scratch = (word_r == wm_state_pkg::WORD_SCRATCH);
    wire logic sel_depth = (word_r == wm_state_pkg::WORD_DEPTH);
    wire logic [25:0] kptr_nxt = sel_kernel ?
        i_PKT_DATA[31:wm_state_pkg::KPTR_LO] : kptr_s;
    wire logic [7:0] btcnt_nxt = sel_thread ?
        i_PKT_DATA[wm_state_pkg::BTCNT_HI:wm_state_pkg::BTCNT_LO] : btcnt_s;
    wire logic prio_nxt = sel_thread ?
        i_PKT_DATA[wm_state_pkg::PRIO_BIT] : prio_s;
    wire logic fpmode_nxt = sel_thread ?
        i_PKT_DATA[wm_state_pkg::FPMODE_BIT] : fpmode_s;
    // either enable sets the one shared thread control bit
    wire logic exc_mask_nxt = sel_thread ? (i_PKT_DATA[wm_state_pkg::ILLOP_EXC_BIT]
        | i_PKT_DATA[wm_state_pkg::MASKSTK_EXC_BIT]) : exc_mask_s;
    wire logic exc_sw_nxt = sel_thread ?
        i_PKT_DATA[wm_state_pkg::SW_EXC_BIT] : exc_sw_s;
    wire logic [21:0] scr_base_nxt = sel_scratch ?
        i_PKT_DATA[31:wm_state_pkg::SCR_BASE_LO] : scr_base_s;
    wire logic [3:0] scr_size_nxt = sel_scratch ?
        i_PKT_DATA[wm_state_pkg::SCR_SIZE_HI:wm_state_pkg::SCR_SIZE_LO] : scr_size_s;
    wire logic stats_nxt = sel_depth ?
        i_PKT_DATA[wm_state_pkg::STATS_EN_BIT] : stats_s;
    wire logic dclear_nxt = sel_depth ?
        i_PKT_DATA[wm_state_pkg::DEPTH_CLEAR_BIT] : dclear_s;
    // clamp out-of-range sizes so the decoded byte count never exceeds 2 MB
    wire logic [3:0] scr_n = (scr_size_nxt > wm_state_pkg::SCR_SIZE_MAX) ?
        wm_state_pkg::SCR_SIZE_MAX : scr_size_nxt;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            wm_state_pkg::ST_HEADER: begin
                if (hdr_take && hdr_ok) begin
                    state_nxt = wm_state_pkg::ST_PAYLOAD;
                end
            end
            wm_state_pkg::ST_PAYLOAD: begin
                if (last_word) begin
                    state_nxt = wm_state_pkg::ST_HEADER;
                end
            end
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            state_r <= wm_state_pkg::ST_HEADER;
            left_r <= 8'h00;
            word_r <= 8'h00;
            o_PKT_READY <= 1'b0;
        end else begin
            state_r <= state_nxt;
            // ready rises on the first edge out of reset and then stays up
            o_PKT_READY <= 1'b1;
            if (hdr_take) begin
                left_r <= hdr_len;
                word_r <= wm_state_pkg::WORD_KERNEL;
            end else if (pay_take) begin
                left_r <= left_r - 8'h01;
                word_r <= word_r + 8'h01;
            end
        end
    end

    // shadow copies collect the payload; the active copies move only on the last word
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            kptr_s <= '0;
            btcnt_s <= '0;
            prio_s <= 1'b0;
            fpmode_s <= 1'b0;
            exc_mask_s <= 1'b0;
            exc_sw_s <= 1'b0;
            scr_base_s <= '0;
            scr_size_s <= '0;
            stats_s <= 1'b0;
            dclear_s <= 1'b0;
        end else if (pay_take) begin
            kptr_s <= kptr_nxt;
            btcnt_s <= btcnt_nxt;
            prio_s <= prio_nxt;
            fpmode_s <= fpmode_nxt;
            exc_mask_s <= exc_mask_nxt;
            exc_sw_s <= exc_sw_nxt;
            scr_base_s <= scr_base_nxt;
            scr_size_s <= scr_size_nxt;
            stats_s <= stats_nxt;
            dclear_s <= dclear_nxt;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            o_KERNEL_PTR <= '0;
            o_BT_COUNT <= '0;
            o_HIGH_PRIO <= 1'b0;
            o_ALT_FP_MODE <= 1'b0;
            o_THREAD_CTL_WORD <= '0;
            o_SCRATCH_BASE <= '0;
            o_SCRATCH_BYTES <= wm_state_pkg::SCR_ONE_KB;
            o_STATS_EN <= 1'b0;
            o_DEPTH_INIT <= 1'b0;
            loaded_r <= 1'b0;
        end else if (last_word) begin
            o_KERNEL_PTR <= kptr_nxt;
            o_BT_COUNT <= btcnt_nxt;
            o_HIGH_PRIO <= prio_nxt;
            o_ALT_FP_MODE <= fpmode_nxt;
            o_THREAD_CTL_WORD <= '0;
            o_THREAD_CTL_WORD[wm_state_pkg::TCW_ILLOP_MASK_BIT] <= exc_mask_nxt;
            o_THREAD_CTL_WORD[wm_state_pkg::TCW_SW_EXC_BIT] <= exc_sw_nxt;
            o_SCRATCH_BASE <= scr_base_nxt;
            o_SCRATCH_BYTES <= wm_state_pkg::SCR_ONE_KB << scr_n;
            o_STATS_EN <= stats_nxt;
            o_DEPTH_INIT <= dclear_nxt;
            loaded_r <= 1'b1;
        end
    end

    // ****************************************
    // pixel scoreboard
    // ****************************************
    logic [wm_state_pkg::SB_DEPTH-1:0] sb_valid_r;
    logic [wm_state_pkg::SB_DEPTH-1:0] sb_done_r;
    logic [wm_state_pkg::SB_DEPTH-1:0] sb_hit;
    logic [wm_state_pkg::PIX_W-1:0] sb_pix_r [wm_state_pkg::SB_DEPTH];
    logic [2:0] wr_ptr_r;
    logic [2:0] rd_ptr_r;
    logic [3:0] count_r;
    logic disp_en_r;

    // a pixel already held by an outstanding thread blocks a new dispatch
    wire logic collide = |sb_hit;
    // ack high blocks a repeat, so a request held over its ack is never taken twice
    wire logic disp_go = i_DISP_REQ & disp_en_r & ~o_DISP_ACK & ~collide
        & (count_r != wm_state_pkg::SB_FULL);
    wire logic retire_go = sb_valid_r[rd_ptr_r] & sb_done_r[rd_ptr_r];

    genvar gi;
    generate
        for (gi = 0; gi < wm_state_pkg::SB_DEPTH; gi++) begin : g_sb
            localparam logic [2:0] IDX = 3'(gi);
            assign sb_hit[gi] = sb_valid_r[gi] && (sb_pix_r[gi] == i_DISP_PIXEL);
            always_ff @(posedge I_CLK) begin
                if (!I_RST_N) begin
                    sb_valid_r[gi] <= 1'b0;
                    sb_done_r[gi] <= 1'b0;
                    sb_pix_r[gi] <= '0;
                end else if (disp_go && wr_ptr_r == IDX) begin
                    sb_valid_r[gi] <= 1'b1;
                    sb_done_r[gi] <= 1'b0;
                    sb_pix_r[gi] <= i_DISP_PIXEL;
                end else if (retire_go && rd_ptr_r == IDX) begin
                    sb_valid_r[gi] <= 1'b0;
                end else if (i_DONE_VALID && i_DONE_TID == IDX && sb_valid_r[gi]) begin
                    sb_done_r[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            o_DISP_ACK <= 1'b0;
            o_DISP_TID <= '0;
            o_RETIRE <= 1'b0;
            o_RETIRE_TID <= '0;
        end else begin
            o_DISP_ACK <= disp_go;
            o_RETIRE <= retire_go;
            if (disp_go) begin
                o_DISP_TID <= wr_ptr_r;
                wr_ptr_r <= wr_ptr_r + 3'h1;
            end
            if (retire_go) begin
                o_RETIRE_TID <= rd_ptr_r;
                rd_ptr_r <= rd_ptr_r + 3'h1;
            end
            count_r <= count_r + {3'h0, disp_go} - {3'h0, retire_go};
        end
    end

    // ****************************************
    // register port
    // ****************************************
    logic [31:0] stats_cnt_r;

    wire logic wr_status = i_REG_WR && (i_REG_ADDR == wm_state_pkg::REG_STATUS);
    wire logic wr_stats = i_REG_WR && (i_REG_ADDR == wm_state_pkg::REG_STATS);
    wire logic wr_control = i_REG_WR && (i_REG_ADDR == wm_state_pkg::REG_CONTROL);
    wire logic hdr_bad = hdr_take & ~hdr_ok;
    // counting stops, value held, while statistics are off
    wire logic stats_inc = disp_go & o_STATS_EN;
    wire logic [31:0] status_word = {24'h0, count_r, 1'b0, loaded_r, hdr_err_r, ~in_header};
    wire logic [31:0] rd_mux = (i_REG_ADDR == wm_state_pkg::REG_STATUS) ? status_word :
        (i_REG_ADDR == wm_state_pkg::REG_STATS) ? stats_cnt_r :
        (i_REG_ADDR == wm_state_pkg::REG_CONTROL) ? {31'h0, disp_en_r} : 32'h0;

    // read data stand in the cycle after each cycle with a read strobe and are zero otherwise
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            o_REG_RDATA <= '0;
        end else begin
            o_REG_RDATA <= i_REG_RD ? rd_mux : 32'h0;
        end
    end

    // a new bad header in the clearing cycle keeps the flag set
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            hdr_err_r <= 1'b0;
        end else if (hdr_bad) begin
            hdr_err_r <= 1'b1;
        end else if (wr_status && i_REG_WDATA[wm_state_pkg::ST_HDR_ERR_BIT]) begin
            hdr_err_r <= 1'b0;
        end
    end

    // a write clears the count; a dispatch in that same cycle is still counted
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            stats_cnt_r <= '0;
        end else if (wr_stats) begin
            stats_cnt_r <= {31'h0, stats_inc};
        end else if (stats_inc) begin
            stats_cnt_r <= stats_cnt_r + 32'h1;
        end
    end

    // disabling dispatch leaves outstanding threads free to finish and retire
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            disp_en_r <= wm_state_pkg::CTL_DISP_EN_RESET;
        end else if (wr_control) begin
            disp_en_r <= i_REG_WDATA[wm_state_pkg::CTL_DISP_EN_BIT];
        end
    end

endmodule : windower_state_packet_decode

`default_nettype wire

// file: verif/raster_decode_checker.sv
`timescale 1ns/1ps
`default_nettype none

module raster_decode_checker (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_N,
    // packet stream and register port
    input wire logic i_PKT_VALID,
    input wire logic o_PKT_READY,
    input wire logic i_REG_RD,
    input wire logic [31:0] o_REG_RDATA,
    // active state
    input wire logic [25:0] o_KERNEL_PTR,
    input wire logic [7:0] o_BT_COUNT,
    input wire logic [31:0] o_THREAD_CTL_WORD,
    input wire logic [21:0] o_SCRATCH_BYTES,
    input wire logic o_STATS_EN,
    input wire logic o_DEPTH_INIT,
    // dispatch and retirement
    input wire logic i_DISP_REQ,
    input wire logic o_DISP_ACK,
    input wire logic [2:0] o_DISP_TID,
    input wire logic o_RETIRE,
    input wire logic [2:0] o_RETIRE_TID
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    // ****
    // shadow of dispatch order, retirement must follow it
    // ****
    logic [2:0] ord_r [8];
    logic [2:0] wp_r;
    logic [2:0] rp_r;
    logic [3:0] cnt_r;
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            wp_r <= 3'h0;
            rp_r <= 3'h0;
            cnt_r <= 4'h0;
        end else begin
            if (o_DISP_ACK) begin
                ord_r[wp_r] <= o_DISP_TID;
                wp_r <= wp_r + 3'h1;
            end
            if (o_RETIRE) rp_r <= rp_r + 3'h1;
            cnt_r <= cnt_r + 4'(o_DISP_ACK) - 4'(o_RETIRE);
        end
    end

    // ****
    // properties
    // ****
    a_reset_clear: assert property ($rose(I_RST_N) |-> !o_PKT_READY &&
        o_KERNEL_PTR == 26'h0 && o_STATS_EN == 1'b0 && o_SCRATCH_BYTES == 22'h000400)
        else $error("state not cleared by reset");
    a_ready_high: assert property ($past(I_RST_N) |-> o_PKT_READY)
        else $error("packet ready low outside reset");
    a_state_hold: assert property (!$stable({o_KERNEL_PTR, o_BT_COUNT, o_THREAD_CTL_WORD,
        o_SCRATCH_BYTES, o_STATS_EN, o_DEPTH_INIT}) |-> $past(i_PKT_VALID && o_PKT_READY))
        else $error("active state changed without a packet word");
    a_tcw_bits: assert property (o_THREAD_CTL_WORD[31:14] == 18'h0 &&
        o_THREAD_CTL_WORD[11:0] == 12'h0) else $error("stray thread control bit");
    a_scr_pow2: assert property ($onehot(o_SCRATCH_BYTES) &&
        o_SCRATCH_BYTES >= 22'h000400) else $error("scratch size not a power of two");
    a_rdata_idle: assert property (!$past(i_REG_RD) |-> o_REG_RDATA == 32'h0)
        else $error("read data without a read");
    a_ack_cause: assert property (o_DISP_ACK |-> $past(i_DISP_REQ) ##1 !o_DISP_ACK)
        else $error("dispatch ack without request or too long");
    a_retire_order: assert property (o_RETIRE |-> o_RETIRE_TID == ord_r[rp_r])
        else $error("thread retired out of order");
    a_sb_bound: assert property (o_DISP_ACK |-> cnt_r < 4'h8)
        else $error("dispatch beyond scoreboard depth");
    c_full: cover property (o_DISP_ACK && cnt_r == 4'h7);
    c_retire: cover property (o_RETIRE);
    c_stats: cover property (o_STATS_EN && o_DISP_ACK);
endmodule : raster_decode_checker

`default_nettype wire

// file: verif/pkt_streamer.sv
`timescale 1ns/1ps
`default_nettype none

module pkt_streamer (
    // clock
    input wire logic i_clk,
    // packet word stream
    input wire logic i_ready,
    output logic o_valid,
    output logic [31:0] o_data
);
    logic slow = 1'b0;
    logic stuck = 1'b0;
    logic [31:0] pw [4];
    initial begin
        o_valid = 1'b0;
        o_data = 32'h0;
    end

    // ****
    // sending, entered right after a rising edge
    // ****
    // an idle data bus carries noise so a stale word is never mistaken for a fresh one
    task automatic idle();
        o_valid <= 1'b0;
        o_data <= $urandom();
    endtask : idle
    task automatic send_word(input logic [31:0] w);
        int n;
        if (slow && $urandom_range(1) == 1) begin
            idle();
            @(posedge i_clk);
        end
        o_valid <= 1'b1;
        o_data <= w;
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (i_ready !== 1'b1 && n < 50);
        if (n == 50) stuck = 1'b1;
        @(posedge i_clk);
    endtask : send_word
    task automatic send_pkt(input logic [7:0] rsv, input logic [7:0] len,
                            input logic [31:0] w1, w2, w3, w4);
        pw[0] = w1 & 32'hffff_ffc0;
        pw[1] = w2 & 32'h03ff_2880;
        pw[2] = w3 & 32'hffff_fc0f;
        pw[3] = {w4[31] & !w4[30], w4[30], 30'h0};
        send_word({wm_state_pkg::GRAPHICS_COMMAND_TYPE, wm_state_pkg::THREE_D_COMMAND_SUBTYPE,
            wm_state_pkg::PIPELINED_STATE_OPCODE, wm_state_pkg::RASTERIZER_STATE_SUBOPC,
            rsv, len});
        for (int i = 0; i <= len; i++) send_word(i < 4 ? pw[i] : $urandom());
        idle();
    endtask : send_pkt
endmodule : pkt_streamer

`default_nettype wire

// file: verif/tb_windower_state_packet_decode.sv
`timescale 1ns/1ps
`default_nettype none

module tb_windower_state_packet_decode;
    localparam logic [113:0] RST_ST = {92'h0, 22'h400, 2'h0};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic req = 1'b0;
    logic done = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [15:0] pix = 16'h0;
    logic [2:0] done_tid = 3'h0;
    logic pkt_valid, pkt_ready, ack, ret, prio, fpm, stats, depth;
    logic [31:0] pkt_data, rdata, tcw;
    logic [25:0] kptr;
    logic [7:0] btc;
    logic [21:0] sbase, sbytes;
    logic [2:0] tid, rtid;
    logic [2:0] tq [$];
    logic [2:0] rq [$];
    int mismatches = 0;
    int tests_run = 0;
    wire logic [113:0] state = {kptr, btc, prio, fpm, tcw, sbase, sbytes, stats, depth};
    always #50 clk = ~clk;
    always @(posedge clk) if (ret === 1'b1) rq.push_back(rtid);

    windower_state_packet_decode DUT (.I_CLK(clk), .I_RST_N(rst_n), .i_PKT_VALID(pkt_valid),
        .i_PKT_DATA(pkt_data), .o_PKT_READY(pkt_ready), .i_REG_ADDR(addr), .i_REG_WDATA(wdata),
        .i_REG_WR(wr), .i_REG_RD(rd), .o_REG_RDATA(rdata), .o_KERNEL_PTR(kptr), .o_BT_COUNT(btc),
        .o_HIGH_PRIO(prio), .o_ALT_FP_MODE(fpm), .o_THREAD_CTL_WORD(tcw), .o_SCRATCH_BASE(sbase),
        .o_SCRATCH_BYTES(sbytes), .o_STATS_EN(stats), .o_DEPTH_INIT(depth), .i_DISP_REQ(req),
        .i_DISP_PIXEL(pix), .o_DISP_ACK(ack), .o_DISP_TID(tid), .i_DONE_VALID(done),
        .i_DONE_TID(done_tid), .o_RETIRE(ret), .o_RETIRE_TID(rtid));
    pkt_streamer u_src (.i_clk(clk), .i_ready(pkt_ready), .o_valid(pkt_valid), .o_data(pkt_data));

    // ****
    // helpers; reg_wr, rd_chk, disp and finish_thread each entered right after a rising edge
    // ****
    function automatic logic [113:0] exp_state(input logic [31:0] w [4]);
        logic [3:0] n;
        n = (w[2][3:0] > 4'hb) ? 4'hb : w[2][3:0];
        return {w[0][31:6], w[1][25:16], 18'h0, w[1][7], w[1][13] | w[1][11], 12'h0,
            w[2][31:10], 22'h400 << n, w[3][31:30]};
    endfunction : exp_state
    task automatic check(input string name, input logic [127:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : reg_wr
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string name);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(name, exp, rdata);
        @(posedge clk);
    endtask : rd_chk
    // a refusal is expected to run the whole wait out
    task automatic disp(input logic [15:0] p, input logic exp_ok);
        int n;
        req <= 1'b1;
        pix <= p;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (ack !== 1'b1 && n < 8);
        if (n < 8) tq.push_back(tid);
        @(posedge clk);
        req <= 1'b0;
        check("dispatch ack", exp_ok, n < 8);
        @(posedge clk);
    endtask : disp
    task automatic finish_thread(input logic [2:0] t);
        done <= 1'b1;
        done_tid <= t;
        @(posedge clk);
        done <= 1'b0;
        @(posedge clk);
    endtask : finish_thread
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    // ****
    // main sequence
    // ****
    initial begin
        int bad [4] = '{29, 27, 24, 16};
        void'($urandom(79));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check("reset state", RST_ST, state);
        @(negedge clk);
        check("packet ready", 1'b1, pkt_ready);
        @(posedge clk);
        rd_chk(4'h8, 32'h1, "control");
        rd_chk(4'h0, 32'h0, "status");
        rd_chk(4'hc, 32'h0, "unmapped");
        u_src.send_word(32'h7814_0003);
        u_src.send_word(32'hffff_ffc0);
        u_src.send_word(32'h03ff_2880);
        u_src.idle();
        @(negedge clk);
        check("partial packet", RST_ST, state);
        @(posedge clk);
        rd_chk(4'h0, 32'h1, "status busy");
        u_src.send_word(32'hffff_fc0b);
        u_src.send_word(32'h4000_0000);
        u_src.idle();
        @(negedge clk);
        check("full packet", exp_state('{32'hffff_ffc0, 32'h03ff_2880, 32'hffff_fc0b,
            32'h4000_0000}), state);
        @(posedge clk);
        foreach (bad[i]) begin
            u_src.send_word(32'h7814_0007 ^ (32'h1 << bad[i]));
            u_src.idle();
            rd_chk(4'h0, 32'h6, "status error");
            reg_wr(4'h0, 32'h2);
        end
        rd_chk(4'h0, 32'h4, "status cleared");
        check("refused header", exp_state('{32'hffff_ffc0, 32'h03ff_2880, 32'hffff_fc0b,
            32'h4000_0000}), state);
        u_src.slow = 1'b1;
        repeat (10) begin
            u_src.send_pkt(8'($urandom()), 8'($urandom_range(9, 3)), $urandom(), $urandom(),
                $urandom(), $urandom());
            @(negedge clk);
            check("random packet", exp_state(u_src.pw), state);
            @(posedge clk);
        end
        u_src.slow = 1'b0;
        u_src.send_pkt(8'h0, 8'h07, 32'h0, 32'h0, 32'h0, 32'h8000_0000);
        reg_wr(4'h4, 32'h0);
        for (int i = 0; i < 9; i++) disp(16'h10 + 16'(i), i < 8);
        for (int i = 7; i >= 0; i--) finish_thread(tq[i]);
        for (int i = 0; i < 40 && rq.size() < 8; i++) @(posedge clk);
        foreach (tq[i]) check("retire tid", tq[i], rq[i]);
        rd_chk(4'h4, 32'h8, "stats count");
        tq.delete();
        disp(16'h40, 1'b1);
        disp(16'h40, 1'b0);
        finish_thread(tq[0]);
        reg_wr(4'h8, 32'h0);
        disp(16'h41, 1'b0);
        reg_wr(4'h8, 32'h1);
        u_src.send_pkt(8'h0, 8'h07, 32'h0, 32'h0, 32'h0, 32'h0);
        disp(16'h42, 1'b1);
        rd_chk(4'h4, 32'h9, "stats held");
        reg_wr(4'h4, 32'h0);
        rd_chk(4'h4, 32'h0, "stats cleared");
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check("second reset", RST_ST, state);
        check("stream stall", 1'b0, u_src.stuck);
        test_done();
    end
endmodule : tb_windower_state_packet_decode

bind windower_state_packet_decode raster_decode_checker u_chk (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
    .i_PKT_VALID(i_PKT_VALID), .o_PKT_READY(o_PKT_READY), .i_REG_RD(i_REG_RD),
    .o_REG_RDATA(o_REG_RDATA), .o_KERNEL_PTR(o_KERNEL_PTR), .o_BT_COUNT(o_BT_COUNT),
    .o_THREAD_CTL_WORD(o_THREAD_CTL_WORD), .o_SCRATCH_BYTES(o_SCRATCH_BYTES),
    .o_STATS_EN(o_STATS_EN), .o_DEPTH_INIT(o_DEPTH_INIT), .i_DISP_REQ(i_DISP_REQ),
    .o_DISP_ACK(o_DISP_ACK), .o_DISP_TID(o_DISP_TID), .o_RETIRE(o_RETIRE),
    .o_RETIRE_TID(o_RETIRE_TID));

`default_nettype wire
